// ### verilog/serws_regs.svh
// Opcodes, field values and timing counts of the serial EEPROM access block
`ifndef SERWS_REGS_SVH
`define SERWS_REGS_SVH

// Command bit 3 is a don't-care, so opcodes are compared under this mask
`define SERWS_OPC_MASK             8'hF7
`define SERWS_SET_WRITE_LATCH_CMD  8'h06
`define SERWS_CLR_WRITE_LATCH_CMD  8'h04
`define SERWS_STATUS_READ_CMD      8'h05
`define SERWS_STATUS_WRITE_CMD     8'h01
`define SERWS_ARRAY_READ_CMD       8'h03
`define SERWS_ARRAY_WRITE_CMD      8'h02

// Status byte shown while an internal write cycle runs
`define SERWS_STATUS_BUSY_VAL      8'hFF

// Address layout
`define SERWS_ADDR_FIELD_BITS      16
`define SERWS_ARRAY_ADDR_BITS      13
`define SERWS_PAGE_BITS            5
`define SERWS_PAGE_BYTES           32

// Self-timed write cycle: longest time, so the count rounds down
`define SERWS_CLK_KHZ              25000
`define SERWS_T_WC_US              2000
`define SERWS_WC_CYCLES (`SERWS_T_WC_US * `SERWS_CLK_KHZ / 1000)

`endif

// ### verilog/serws_pkg.sv
// Types shared by the serial EEPROM access block
`default_nettype none

package serws_pkg;

    // Link-side phase of a chip-select frame
    typedef enum logic [2:0] {
        SERWS_CMD    = 3'b000,
        SERWS_ADDR   = 3'b001,
        SERWS_READ   = 3'b010,
        SERWS_WRITE  = 3'b011,
        SERWS_STAT   = 3'b100,
        SERWS_STWR   = 3'b101,
        SERWS_IGNORE = 3'b110
    } serws_link_mode_t;

    // System-side programming phase
    typedef enum logic [1:0] {
        SERWS_IDLE = 2'b00,
        SERWS_COPY = 2'b01,
        SERWS_PROG = 2'b10
    } serws_prog_mode_t;

    // Status byte as it is shifted out
    typedef struct packed {
        logic       protect_pin_enable_bit;
        logic [2:0] zero;
        logic       block_protect_hi;
        logic       block_protect_lo;
        logic       write_latch;
        logic       busy;
    } serws_status_t;

    // State of the link (serial clock) domain except frame_fresh and the output shifter
    typedef struct packed {
        serws_link_mode_t mode;
        logic             is_read;
        logic [2:0]       bcnt;
        logic [3:0]       acnt;
        logic [7:0]       sh;
        logic [15:0]      addr;
        logic             write_latch;
        logic             block_protect_hi;
        logic             block_protect_lo;
        logic             protect_pin_enable_bit;
        logic             wr_ok;
        logic             out_load;
        logic             out_stat;
        logic [31:0]      mask;
        logic             wp_s1;
        logic             wp_s2;
        logic             busy_s1;
        logic             busy_s2;
        logic             clr_s1;
        logic             clr_s2;
        logic             clr_seen;
    } serws_link_t;

    // Whole state of the system clock domain
    typedef struct packed {
        serws_prog_mode_t mode;
        logic             cs_s1;
        logic             cs_s2;
        logic             cs_d;
        logic             ok_s1;
        logic             ok_s2;
        logic [5:0]       idx;
        logic             cp_vld;
        logic [4:0]       cp_idx;
        logic [10:0]      page;
        logic [31:0]      mask;
        logic [31:0]      timer;
        logic             busy;
        logic             clr_tog;
    } serws_prog_t;

endpackage

`default_nettype wire

// ### verilog/serws_dpram.sv
// Two-clock memory with registered read data
`default_nettype none

module serws_dpram #(
    parameter int DW = 8,
    parameter int AW = 13
) (
    input  wire logic          wr_clk,
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [DW-1:0] wr_data,
    input  wire logic          rd_clk,
    input  wire logic [AW-1:0] rd_addr,
    output var  logic [DW-1:0] rd_data
);

    logic [DW-1:0] mem [0:(1<<AW)-1];

    // Write port
    always_ff @(posedge wr_clk)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Read port; data appear one edge after the address
    always_ff @(posedge rd_clk)
    begin
        rd_data <= mem[rd_addr];
    end

endmodule

`default_nettype wire

// ### verilog/serws_top.sv
// Serial EEPROM read, write, page and write-cycle sequencing
// Notes on behaviour
// RQ1 - Master sends read opcode then 16-bit address
// RQ2 - Serial input ignored after read address phase
// RQ3 - Addressed byte shifted out MSB first
// RQ4 - Master ends single read after one byte
// RQ5 - Address increments, bytes stream while selected
// RQ6 - Read address wraps to zero at top
// RQ7 - Upper address bits beyond density are ignored
// RQ8 - Master sends write-enable in separate frame first
// RQ9 - Bytes inside protected range are never programmed
// RQ10 - During write cycle only status read works
// RQ11 - Master sends write opcode, address, data bytes
// RQ12 - Programming starts when chip select rises
// RQ13 - Write valid only if select rises on byte boundary
// RQ14 - Page write advances only five low bits
// RQ15 - Excess page bytes wrap, replacing earlier ones
// RQ16 - Write latch clears when write cycle ends
// RQ17 - Write without latch set is discarded
// RQ18 - Master needs new select falling edge after
// RQ19 - Status bit 0 shows write cycle running
// RQ20 - Eight-bit opcodes with bit 3 don't-care
// RQ21 - MSB first; frames start at select falling
// RQ22 - Sample input rising, change output falling
// RQ23 - Pin low plus enable bit blocks status write
// RQ24 - Write cycle timed by configurable cycle counter
`include "serws_regs.svh"
`default_nettype none

module serws_top #(
    parameter int ADDR_W    = `SERWS_ARRAY_ADDR_BITS,
    parameter int WC_CYCLES = `SERWS_WC_CYCLES
) (
    input  wire logic clk_sys,
    input  wire logic resetn,
    input  wire logic sck,
    input  wire logic cs_n,
    input  wire logic si,
    input  wire logic wp_n,
    output var  logic so,
    output var  logic so_oe,
    output var  logic busy
);

    localparam logic [15:0] AMASK = 16'((32'd1 << ADDR_W) - 32'd1);

    serws_pkg::serws_link_t   s;
    serws_pkg::serws_link_t   next_s;
    serws_pkg::serws_prog_t   p;
    serws_pkg::serws_prog_t   next_p;
    serws_pkg::serws_status_t stat;
    logic                     frame_fresh;
    logic [7:0]               so_byte;
    logic                     so_act;
    logic                     buf_we;
    logic [7:0]               buf_q;
    logic [7:0]               arr_q;
    logic                     arr_we;
    logic [7:0]               opc;
    logic                     hw_prot;

    // True when the address lies in the block-protected range
    function automatic logic addr_protected(
        input logic [15:0] a,
        input logic        hi,
        input logic        lo
    );
        case ({hi, lo})
            2'b00:   return 1'b0;
            2'b01:   return a[ADDR_W-1] & a[ADDR_W-2];
            2'b10:   return a[ADDR_W-1];
            default: return 1'b1;
        endcase
    endfunction

    // Chip select high marks the next sck edge as the start of a frame;
    // the rest of the link state only moves on sck, so it stays readable
    // by the system side after the frame ends
    always_ff @(posedge sck or posedge cs_n or negedge resetn)
    begin
        if (!resetn)
        begin
            frame_fresh <= 1'b1;
        end
        else if (cs_n)
        begin
            frame_fresh <= 1'b1; // RQ21
        end
        else
        begin
            frame_fresh <= 1'b0;
        end
    end

    // Status byte; all ones while the write cycle runs
    always_comb
    begin
        stat = '0;
        stat.protect_pin_enable_bit = s.protect_pin_enable_bit;
        stat.block_protect_hi       = s.block_protect_hi;
        stat.block_protect_lo       = s.block_protect_lo;
        // A clear still in the synchroniser already counts, so a poll that
        // sees the cycle finished never sees the latch still set
        stat.write_latch            = s.write_latch
                                    & (s.clr_s2 == s.clr_seen); // RQ16
        if (s.busy_s2)
        begin
            stat = `SERWS_STATUS_BUSY_VAL; // RQ19
        end
    end

    assign hw_prot = s.protect_pin_enable_bit & ~s.wp_s2;
    assign opc     = {s.sh[6:0], si} & `SERWS_OPC_MASK; // RQ20
    assign buf_we  = (next_s.mode == serws_pkg::SERWS_WRITE)
                   & (s.mode != serws_pkg::SERWS_ADDR)
                   & ~frame_fresh & (s.bcnt == 3'd7);

    // Link decoder: one input bit taken per rising sck edge
    always_comb
    begin
        serws_pkg::serws_link_t b;
        b = s;
        if (frame_fresh)
        begin
            b.mode     = serws_pkg::SERWS_CMD;
            b.bcnt     = 3'd0;
            b.acnt     = 4'd0;
            b.wr_ok    = 1'b0;
            b.out_load = 1'b0;
        end
        next_s          = b;
        next_s.out_load = 1'b0;
        next_s.sh       = {b.sh[6:0], si}; // RQ22
        next_s.bcnt     = b.bcnt + 3'd1;
        next_s.wp_s1    = wp_n;
        next_s.wp_s2    = s.wp_s1;
        next_s.busy_s1  = p.busy;
        next_s.busy_s2  = s.busy_s1;
        next_s.clr_s1   = p.clr_tog;
        next_s.clr_s2   = s.clr_s1;
        next_s.clr_seen = s.clr_s2;
        // End of write cycle clears the latch; a set below wins
        if (s.clr_s2 != s.clr_seen)
        begin
            next_s.write_latch = 1'b0; // RQ16
        end
        case (b.mode)
            serws_pkg::SERWS_CMD:
            begin
                if (b.bcnt == 3'd7)
                begin
                    next_s.mode = serws_pkg::SERWS_IGNORE;
                    if (opc == `SERWS_STATUS_READ_CMD)
                    begin
                        next_s.mode     = serws_pkg::SERWS_STAT;
                        next_s.out_load = 1'b1;
                        next_s.out_stat = 1'b1;
                    end
                    else if (b.busy_s2)
                    begin
                        next_s.mode = serws_pkg::SERWS_IGNORE; // RQ10
                    end
                    else if (opc == `SERWS_SET_WRITE_LATCH_CMD)
                    begin
                        next_s.write_latch = 1'b1;
                    end
                    else if (opc == `SERWS_CLR_WRITE_LATCH_CMD)
                    begin
                        next_s.write_latch = 1'b0;
                    end
                    else if (opc == `SERWS_ARRAY_READ_CMD)
                    begin
                        next_s.mode    = serws_pkg::SERWS_ADDR; // RQ1
                        next_s.is_read = 1'b1;
                    end
                    else if (opc == `SERWS_ARRAY_WRITE_CMD && b.write_latch)
                    begin
                        next_s.mode    = serws_pkg::SERWS_ADDR; // RQ17
                        next_s.is_read = 1'b0;
                    end
                    else if (opc == `SERWS_STATUS_WRITE_CMD && b.write_latch)
                    begin
                        next_s.mode = serws_pkg::SERWS_STWR;
                    end
                end
            end
            serws_pkg::SERWS_ADDR:
            begin
                next_s.addr = {b.addr[14:0], si}; // RQ21
                next_s.acnt = b.acnt + 4'd1;
                if (b.acnt == 4'd15)
                begin
                    next_s.addr = {b.addr[14:0], si} & AMASK; // RQ7
                    if (b.is_read)
                    begin
                        next_s.mode     = serws_pkg::SERWS_READ; // RQ3
                        next_s.out_load = 1'b1;
                        next_s.out_stat = 1'b0;
                    end
                    else
                    begin
                        next_s.mode = serws_pkg::SERWS_WRITE; // RQ11
                        next_s.mask = 32'h0000_0000;
                    end
                end
            end
            serws_pkg::SERWS_READ:
            begin
                // Serial input is not looked at here
                if (b.bcnt == 3'd7) // RQ2
                begin
                    next_s.addr     = (b.addr + 16'h0001) & AMASK; // RQ6
                    next_s.out_load = 1'b1; // RQ5
                end
            end
            serws_pkg::SERWS_WRITE:
            begin
                next_s.wr_ok = 1'b0; // RQ13
                if (b.bcnt == 3'd7)
                begin
                    next_s.wr_ok = 1'b1; // RQ13
                    if (!addr_protected(b.addr, b.block_protect_hi,
                                        b.block_protect_lo))
                    begin
                        next_s.mask[b.addr[4:0]] = 1'b1; // RQ9
                    end
                    // Only the in-page bits advance, so bytes wrap
                    next_s.addr[4:0] = b.addr[4:0] + 5'd1; // RQ14 RQ15
                end
            end
            serws_pkg::SERWS_STAT:
            begin
                if (b.bcnt == 3'd7)
                begin
                    next_s.out_load = 1'b1;
                end
            end
            serws_pkg::SERWS_STWR:
            begin
                if (b.bcnt == 3'd7)
                begin
                    next_s.mode        = serws_pkg::SERWS_IGNORE;
                    next_s.write_latch = 1'b0;
                    if (!hw_prot) // RQ23
                    begin
                        next_s.protect_pin_enable_bit = next_s.sh[7];
                        next_s.block_protect_hi       = next_s.sh[3];
                        next_s.block_protect_lo       = next_s.sh[2];
                    end
                end
            end
            default:
            begin
                next_s.mode = serws_pkg::SERWS_IGNORE;
            end
        endcase
    end

    // Link state register
    always_ff @(posedge sck or negedge resetn)
    begin
        if (!resetn)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    // Output shifter moves on the falling edge so data settle before the
    // master samples on the next rising edge
    always_ff @(negedge sck or negedge resetn)
    begin
        if (!resetn)
        begin
            so_byte <= 8'h00;
            so_act  <= 1'b0;
        end
        else
        begin
            so_act <= (s.mode == serws_pkg::SERWS_READ)
                    | (s.mode == serws_pkg::SERWS_STAT);
            if (s.out_load)
            begin
                so_byte <= s.out_stat ? stat : arr_q; // RQ3 RQ22
            end
            else
            begin
                so_byte <= {so_byte[6:0], 1'b0};
            end
        end
    end

    assign so    = so_byte[7];
    // so_act keeps its last value over the idle gap between frames, so the
    // current phase gates it too; otherwise the pin would glitch on at the
    // first rising edge of the next frame
    assign so_oe = ~cs_n & ~frame_fresh & so_act
                 & ((s.mode == serws_pkg::SERWS_READ)
                 | (s.mode == serws_pkg::SERWS_STAT)); // RQ3
    assign busy  = p.busy;

    // Page buffer: filled on sck, drained on the system clock
    serws_dpram #(
        .DW (8),
        .AW (`SERWS_PAGE_BITS)
    ) u_page (
        .wr_clk  (sck),
        .wr_en   (buf_we),
        .wr_addr (s.addr[4:0]),
        .wr_data (next_s.sh),
        .rd_clk  (clk_sys),
        .rd_addr (p.idx[4:0]),
        .rd_data (buf_q)
    );

    // Array: programmed on the system clock, read on sck
    serws_dpram #(
        .DW (8),
        .AW (ADDR_W)
    ) u_array (
        .wr_clk  (clk_sys),
        .wr_en   (arr_we),
        .wr_addr (ADDR_W'({p.page, p.cp_idx})),
        .wr_data (buf_q),
        .rd_clk  (sck),
        .rd_addr (next_s.addr[ADDR_W-1:0]),
        .rd_data (arr_q)
    );

    assign arr_we = p.cp_vld & p.mask[p.cp_idx];

    // Write cycle sequencer. Page address and mask are read straight from
    // the link side: sck is quiet after select rises and the synced
    // select edge is the handshake that makes them safe to take
    always_comb
    begin
        next_p       = p;
        next_p.cs_s1 = cs_n;
        next_p.cs_s2 = p.cs_s1;
        next_p.cs_d  = p.cs_s2;
        next_p.ok_s1 = s.wr_ok;
        next_p.ok_s2 = p.ok_s1;
        case (p.mode)
            serws_pkg::SERWS_IDLE:
            begin
                if (p.cs_s2 && !p.cs_d && p.ok_s2 &&
                    s.mask != 32'h0000_0000) // RQ12
                begin
                    next_p.mode   = serws_pkg::SERWS_COPY;
                    next_p.busy   = 1'b1; // RQ19
                    next_p.idx    = 6'd0;
                    next_p.cp_vld = 1'b0;
                    next_p.page   = s.addr[15:5];
                    next_p.mask   = s.mask;
                end
            end
            serws_pkg::SERWS_COPY:
            begin
                next_p.cp_vld = 1'b1;
                next_p.cp_idx = p.idx[4:0];
                next_p.idx    = p.idx + 6'd1;
                if (p.idx == 6'(`SERWS_PAGE_BYTES))
                begin
                    next_p.cp_vld = 1'b0;
                    next_p.mode   = serws_pkg::SERWS_PROG;
                    next_p.timer  = 32'h0000_0000;
                end
            end
            serws_pkg::SERWS_PROG:
            begin
                next_p.timer = p.timer + 32'h0000_0001; // RQ24
                if (p.timer >= 32'(WC_CYCLES - 1))
                begin
                    next_p.mode    = serws_pkg::SERWS_IDLE;
                    next_p.busy    = 1'b0; // RQ19
                    next_p.clr_tog = ~p.clr_tog; // RQ16
                end
            end
            default:
            begin
                next_p.mode = serws_pkg::SERWS_IDLE;
            end
        endcase
    end

    // System state register
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            p <= '0;
        end
        else
        begin
            p <= next_p;
        end
    end

endmodule

`default_nettype wire

// ### dv/serws_top_assertions.sv
// Port-level concurrent checks for the serial EEPROM access block
`default_nettype none

module serws_top_assertions #(
    parameter int WC_CYCLES = 200
) (
    input  wire logic clk_sys,
    input  wire logic resetn,
    input  wire logic sck,
    input  wire logic cs_n,
    input  wire logic si,
    input  wire logic wp_n,
    input  wire logic so,
    input  wire logic so_oe,
    input  wire logic busy
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);

    // Length of the current busy run, so both limits of the cycle are seen
    logic [31:0] run_cnt;

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            run_cnt <= 32'h0000_0000;
        else if (busy)
            run_cnt <= run_cnt + 32'h0000_0001;
        else
            run_cnt <= 32'h0000_0000;
    end

    // A write cycle, once begun, is never shorter than a few cycles
    sequence busy_run;
        busy [*8];
    endsequence

    // A frame closes with the select line back high
    sequence frame_closed;
        cs_n && $past(cs_n);
    endsequence

    chk_oe_deselect: assert property (cs_n |-> !so_oe)
        else $error("output driven while deselected");
    chk_oe_fall_edge: assert property ($rose(so_oe) |-> !sck && !cs_n)
        else $error("output enabled outside sck low phase");
    chk_so_fall_edge: assert property ($changed(so) |-> !sck)
        else $error("serial output moved while sck high");
    chk_oe_held: assert property ($fell(so_oe) |-> cs_n)
        else $error("output dropped while still selected");
    chk_busy_cs_high: assert property ($rose(busy) |-> frame_closed)
        else $error("write cycle began inside a frame");
    chk_busy_run_min: assert property ($rose(busy) |-> busy_run)
        else $error("write cycle ended at once");
    chk_busy_len_min: assert property ($fell(busy) |-> run_cnt >= WC_CYCLES)
        else $error("write cycle shorter than timer");
    chk_busy_len_max: assert property (busy |-> run_cnt <= WC_CYCLES + 40)
        else $error("write cycle overran timer");
endmodule

bind serws_top serws_top_assertions #(.WC_CYCLES(WC_CYCLES)) u_chk (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .sck     (sck),
    .cs_n    (cs_n),
    .si      (si),
    .wp_n    (wp_n),
    .so      (so),
    .so_oe   (so_oe),
    .busy    (busy)
);

`default_nettype wire

// ### dv/serws_master.sv
// Mode-0 serial master model that frames commands for the EEPROM block
`default_nettype none

module serws_master (
    output var  logic sck,
    output var  logic cs_n,
    output var  logic si,
    input  wire logic so,
    input  wire logic so_oe
);
    timeunit 1ns;
    timeprecision 100ps;

    initial
    begin
        sck  = 1'b0;
        cs_n = 1'b1;
        si   = 1'b1;
    end

    // Odd offset keeps sck unrelated in phase to the system clock
    task automatic open_frame();
        #13;
        cs_n = 1'b0;
        #80;
    endtask

    // MSB first; undriven output reads unknown so it passes only a check that expects unknown
    task automatic shift(input logic [7:0] tx, input int n,
                         output logic [7:0] rx);
        rx = 8'hxx;
        for (int i = 7; i > 7 - n; i--)
        begin
            si = tx[i];
            #80;
            sck = 1'b1;
            rx[i] = so_oe ? so : 1'bx;
            #80;
            sck = 1'b0;
        end
    endtask

    // Close in the low phase after the last bit, then keep select high
    task automatic close_frame();
        #40;
        cs_n = 1'b1;
        si   = ~si;
        #200;
    endtask
endmodule

`default_nettype wire

// ### dv/spi_eeprom_read_write_seq_test.sv
// Self-checking bench for the serial EEPROM access block
`default_nettype none

module spi_eeprom_read_write_seq_test;
    timeunit 1ns;
    timeprecision 100ps;

    logic       clk_sys;
    logic       resetn;
    logic       wp_n;
    logic       sck;
    logic       cs_n;
    logic       si;
    logic       so;
    logic       so_oe;
    logic       busy;
    logic [7:0] r;
    logic [7:0] s;
    logic [7:0] d;
    logic [7:0] img [0:31];
    int         error_cnt;
    int         comparisons;
    int         cycles;

    serws_top #(.WC_CYCLES(200)) dut (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .sck     (sck),
        .cs_n    (cs_n),
        .si      (si),
        .wp_n    (wp_n),
        .so      (so),
        .so_oe   (so_oe),
        .busy    (busy)
    );

    serws_master m (
        .sck   (sck),
        .cs_n  (cs_n),
        .si    (si),
        .so    (so),
        .so_oe (so_oe)
    );

    initial
    begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    task automatic stop_test();
        if (error_cnt == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic xb(input logic [7:0] tx, output logic [7:0] rx);
        m.shift(tx, 8, rx);
    endtask

    // Opcode, then the two address bytes when asked for
    task automatic hdr(input logic [7:0] op, input logic [15:0] a,
                       input logic with_addr);
        m.open_frame();
        xb(op, r);
        if (with_addr)
        begin
            xb(a[15:8], r);
            xb(a[7:0], r);
        end
    endtask

    task automatic one(input logic [7:0] op);
        hdr(op, 16'h0000, 1'b0);
        m.close_frame();
    endtask

    task automatic status();
        hdr(8'h05, 16'h0000, 1'b0);
        xb(8'h00, s);
        m.close_frame();
    endtask

    // Leaves time for a write cycle to start before busy is looked at
    task automatic idle();
        repeat (10) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask

    // Hang guard, far above the few thousand cycles the run needs
    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            error_cnt++;
            stop_test();
        end
    end

    initial
    begin
        resetn <= 1'b0;
        wp_n <= 1'b1;
        repeat (8) @(posedge clk_sys);
        resetn <= 1'b1;
        idle();
        check({7'h00, busy}, 8'h00);
        status();
        check(s, 8'h00);
        // Write with the latch clear
        hdr(8'h02, 16'h0010, 1'b1);
        xb(8'hA5, r);
        m.close_frame();
        idle();
        check({7'h00, busy}, 8'h00);
        one(8'h0E);
        status();
        check(s, 8'h02);
        // Select rises in mid-byte
        hdr(8'h02, 16'h0000, 1'b1);
        xb(8'h11, r);
        m.shift(8'h22, 5, r);
        m.close_frame();
        idle();
        check({7'h00, busy}, 8'h00);
        // Page write of 34 bytes from offset 30, upper bits don't-care
        one(8'h06);
        hdr(8'h02, 16'hE01E, 1'b1);
        for (int k = 0; k < 34; k++)
        begin
            d = 8'h40 + 8'(k);
            img[5'(30 + k)] = d;
            xb(d, r);
        end
        check({7'h00, busy}, 8'h00);
        m.close_frame();
        idle();
        check({7'h00, busy}, 8'h01);
        status();
        check(s, 8'hFF);
        hdr(8'h03, 16'h0000, 1'b1);
        xb(8'h00, r);
        m.close_frame();
        check(r, 8'hxx);
        // Poll until ready, bounded
        for (int i = 0; i < 30 && s[0] !== 1'b0; i++)
            status();
        check(s, 8'h00);
        // Stream back with noise on serial input
        hdr(8'h03, 16'hC000, 1'b1);
        for (int k = 0; k < 32; k++)
        begin
            xb(8'hA5 ^ 8'(k), r);
            check(r, img[k]);
        end
        m.close_frame();
        hdr(8'h03, 16'h1FFF, 1'b1);
        xb(8'h00, r);
        xb(8'h00, r);
        m.close_frame();
        check(r, img[0]);
        // Protect everything, then engage the pin
        one(8'h06);
        hdr(8'h01, 16'h0000, 1'b0);
        xb(8'h8C, r);
        m.close_frame();
        status();
        check(s, 8'h8C);
        @(posedge clk_sys);
        wp_n <= 1'b0;
        one(8'h06);
        hdr(8'h02, 16'h0005, 1'b1);
        xb(8'h00, r);
        m.close_frame();
        idle();
        check({7'h00, busy}, 8'h00);
        status();
        check(s, 8'h8E);
        hdr(8'h01, 16'h0000, 1'b0);
        xb(8'h00, r);
        m.close_frame();
        status();
        check(s & 8'hFD, 8'h8C);
        hdr(8'h03, 16'h0005, 1'b1);
        xb(8'h00, r);
        m.close_frame();
        check(r, img[5]);
        stop_test();
    end
endmodule

`default_nettype wire
